/* shared/abd_pkg.sv */
// Constants, types and helpers shared by the block decrypt front end
package abd_pkg;

	localparam logic [7:0] ABD_ADDR_BCFG  = 8'hE9;
	localparam logic [7:0] ABD_ADDR_DCFG  = 8'hEA;
	localparam logic [7:0] ABD_ADDR_BIN   = 8'hEB;
	localparam logic [7:0] ABD_ADDR_KIN   = 8'hEC;
	localparam logic [7:0] ABD_ADDR_XIN   = 8'hED;
	localparam logic [7:0] ABD_ADDR_YOUT  = 8'hEE;

	localparam int         ABD_BCFG_KS_LSB   = 0;
	localparam int         ABD_BCFG_DEC_BIT  = 2;
	localparam int         ABD_BCFG_EN_BIT   = 3;
	localparam int         ABD_BCFG_DONE_BIT = 5;
	localparam int         ABD_DCFG_XOR_BIT  = 0;
	localparam int         ABD_DCFG_SEL_LSB  = 1;

	localparam logic [7:0] ABD_BCFG_RESET = 8'h00;
	localparam logic [7:0] ABD_DCFG_RESET = 8'h00;
	localparam logic [7:0] ABD_XIN_RESET  = 8'h00;
	localparam logic [7:0] ABD_UNMAPPED   = 8'h00;

	localparam logic [4:0] ABD_BLOCK_BYTES = 5'h10;
	localparam logic [5:0] ABD_KEY128      = 6'h10;
	localparam logic [5:0] ABD_KEY192      = 6'h18;
	localparam logic [5:0] ABD_KEY256      = 6'h20;

	localparam logic [1:0] ABD_OUT_DIRECT = 2'h0;
	localparam logic [1:0] ABD_OUT_XOR    = 2'h1;
	localparam logic [1:0] ABD_OUT_INVKEY = 2'h2;

	localparam int         ABD_BUF_DEPTH = 2;
	localparam int         ABD_BUF_WIDTH = 16;

	typedef enum logic {
		ABD_LOAD,
		ABD_BUSY
	} abd_state_t;

	// Key bytes expected for a key-size code; the spare code acts as 128
	function automatic logic [5:0] abd_key_bytes(input logic [1:0] ks);
		case (ks)
			2'h1:    abd_key_bytes = ABD_KEY192;
			2'h2:    abd_key_bytes = ABD_KEY256;
			default: abd_key_bytes = ABD_KEY128;
		endcase
	endfunction : abd_key_bytes

endpackage : abd_pkg

/* hdl/abd_pair_buffer.sv */
// Small valid/ready buffer holding result entries from the cipher core
`timescale 1ns/1ps
module abd_pair_buffer #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             clr,
	input  wire logic             in_valid,
	output      logic             in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output      logic             out_valid,
	input  wire logic             out_ready,
	output      logic [WIDTH-1:0] out_data
);
	// Depth must be a power of two so the pointers wrap by themselves
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [CW-1:0]               cnt;
		logic                        rdy;
		logic                        vld;
	} abd_buf_t;

	localparam abd_buf_t BUF_RESET = '{mem: '0, wp: '0, rp: '0, cnt: '0,
		rdy: 1'b1, vld: 1'b0};

	abd_buf_t st;
	abd_buf_t next_st;
	logic     push;
	logic     pop;

	always_comb begin
		next_st = st;
		push = in_valid && st.rdy;
		pop = out_ready && st.vld;
		if (clr) begin
			next_st.wp = '0;
			next_st.rp = '0;
			next_st.cnt = '0;
		end else begin
			if (push) begin
				next_st.mem[st.wp] = in_data;
				next_st.wp = st.wp + AW'(1);
			end
			if (pop) begin
				next_st.rp = st.rp + AW'(1);
			end
			next_st.cnt = st.cnt + CW'(push) - CW'(pop);
		end
		// Flags come from the next count so ready and valid are flops
		next_st.rdy = (next_st.cnt != CW'(DEPTH));
		next_st.vld = (next_st.cnt != '0);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= BUF_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign in_ready = st.rdy;
	assign out_valid = st.vld;
	assign out_data = st.mem[st.rp];

	full_stalls_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st.cnt == CW'(DEPTH)) |-> !in_ready)
		else $error("buffer full but still ready");

	head_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(out_valid && !out_ready && !clr) |=>
		(out_valid && $stable(out_data)))
		else $error("stalled head entry changed or vanished");

	count_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
		st.cnt <= CW'(DEPTH))
		else $error("buffer count beyond depth");

endmodule : abd_pair_buffer

/* hdl/abd_sfr_path.sv */
// SFR front end of the block cipher used for block decryption
`timescale 1ns/1ps
// Function
// - Block config bits 1:0 select key size and thus expected key bytes.
// - Block config bit 2 sets the core to decrypt direction.
// - Block config bit 3 enables the core; inactive while clear.
// - Block loads as 16 pairs: data byte then key byte, in order.
// - For 192/256-bit keys remaining key bytes follow the pairs.
// - Completion shows as done interrupt and block config bit 5.
// - After completion sixteen result bytes are read from the result port.
// - Configuration is kept between blocks; only data steps repeat.
// - Data config bits 2:1 pick direct, XOR-ed or inverse key output.
// - With data config bit 0 set, data bytes are XOR-ed with operand; key bytes pass unchanged.
// - With data config bit 0 clear, input bytes pass unchanged.
// - Data config resets to zero; bits 7:3 read only as zero.
module abd_sfr_path (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output      logic [7:0] sfr_rdata,
	output      logic       done_irq,
	output      logic [1:0] core_key_size,
	output      logic       core_decrypt,
	output      logic       core_enable,
	output      logic       core_in_valid,
	output      logic [7:0] core_in_data,
	output      logic       core_in_is_key,
	output      logic       core_start,
	input  wire logic       core_done,
	input  wire logic       core_res_valid,
	output      logic       core_res_ready,
	input  wire logic [7:0] core_res_data,
	input  wire logic [7:0] core_res_inv_key
);
	typedef struct packed {
		abd_pkg::abd_state_t state;
		logic [1:0]          key_size;
		logic                decrypt;
		logic                enable;
		logic                done;
		logic                xor_in;
		logic [1:0]          out_sel;
		logic [7:0]          xin;
		logic [4:0]          pairs;
		logic [5:0]          keys;
		logic                expect_key;
		logic [7:0]          rdata;
		logic                in_valid;
		logic [7:0]          in_data;
		logic                in_is_key;
		logic                start;
	} abd_regs_t;

	abd_regs_t  st;
	abd_regs_t  next_st;
	logic       hit_bcfg;
	logic       hit_dcfg;
	logic       hit_bin;
	logic       hit_kin;
	logic       hit_xin;
	logic       hit_yout;
	logic       acc_bin;
	logic       acc_kin;
	logic [5:0] need;
	logic       buf_clr;
	logic       buf_pop;
	logic       buf_valid;
	logic [15:0] buf_data;

	function automatic logic [7:0] abd_result_byte(input logic [1:0] sel,
		input logic [15:0] ent, input logic [7:0] x);
		case (sel)
			abd_pkg::ABD_OUT_XOR:    abd_result_byte = ent[7:0] ^ x;
			abd_pkg::ABD_OUT_INVKEY: abd_result_byte = ent[15:8];
			// Reserved code falls back to direct data
			default:                 abd_result_byte = ent[7:0];
		endcase
	endfunction : abd_result_byte

	always_comb begin
		next_st = st;
		next_st.in_valid = 1'b0;
		next_st.start = 1'b0;
		buf_clr = 1'b0;
		buf_pop = 1'b0;
		hit_bcfg = 1'b0;
		hit_dcfg = 1'b0;
		hit_bin = 1'b0;
		hit_kin = 1'b0;
		hit_xin = 1'b0;
		hit_yout = 1'b0;
		if (sfr_addr == abd_pkg::ABD_ADDR_BCFG) begin
			hit_bcfg = 1'b1;
		end else if (sfr_addr == abd_pkg::ABD_ADDR_DCFG) begin
			hit_dcfg = 1'b1;
		end else if (sfr_addr == abd_pkg::ABD_ADDR_BIN) begin
			hit_bin = 1'b1;
		end else if (sfr_addr == abd_pkg::ABD_ADDR_KIN) begin
			hit_kin = 1'b1;
		end else if (sfr_addr == abd_pkg::ABD_ADDR_XIN) begin
			hit_xin = 1'b1;
		end else if (sfr_addr == abd_pkg::ABD_ADDR_YOUT) begin
			hit_yout = 1'b1;
		end
		need = abd_pkg::abd_key_bytes(st.key_size);
		// Out-of-turn bytes are dropped rather than shifting the pairing
		acc_bin = sfr_wr && hit_bin && st.enable &&
			(st.state == abd_pkg::ABD_LOAD) && !st.expect_key &&
			(st.pairs != abd_pkg::ABD_BLOCK_BYTES);
		acc_kin = sfr_wr && hit_kin && st.enable &&
			(st.state == abd_pkg::ABD_LOAD) && (st.expect_key ||
			((st.pairs == abd_pkg::ABD_BLOCK_BYTES) &&
			(st.keys < need)));

		if (sfr_wr && hit_bcfg) begin
			next_st.key_size = sfr_wdata[abd_pkg::ABD_BCFG_KS_LSB +: 2];
			next_st.decrypt = sfr_wdata[abd_pkg::ABD_BCFG_DEC_BIT];
			next_st.enable = sfr_wdata[abd_pkg::ABD_BCFG_EN_BIT];
			if (!sfr_wdata[abd_pkg::ABD_BCFG_DONE_BIT]) begin
				next_st.done = 1'b0;
			end
			if (sfr_wdata == abd_pkg::ABD_BCFG_RESET) begin
				next_st.state = abd_pkg::ABD_LOAD;
				next_st.pairs = '0;
				next_st.keys = '0;
				next_st.expect_key = 1'b0;
				buf_clr = 1'b1;
			end
		end
		if (sfr_wr && hit_dcfg) begin
			next_st.xor_in = sfr_wdata[abd_pkg::ABD_DCFG_XOR_BIT];
			next_st.out_sel = sfr_wdata[abd_pkg::ABD_DCFG_SEL_LSB +: 2];
		end
		if (sfr_wr && hit_xin) begin
			next_st.xin = sfr_wdata;
		end

		if (acc_bin) begin
			next_st.in_valid = 1'b1;
			next_st.in_is_key = 1'b0;
			if (st.xor_in) begin
				next_st.in_data = sfr_wdata ^ st.xin;
			end else begin
				next_st.in_data = sfr_wdata;
			end
			next_st.expect_key = 1'b1;
			if ((st.pairs == '0) && (st.keys == '0)) begin
				next_st.done = 1'b0;
			end
		end
		if (acc_kin) begin
			next_st.in_valid = 1'b1;
			next_st.in_is_key = 1'b1;
			next_st.in_data = sfr_wdata;
			next_st.keys = st.keys + 6'h01;
			if (st.expect_key) begin
				next_st.pairs = st.pairs + 5'h01;
				next_st.expect_key = 1'b0;
			end
			if ((next_st.pairs == abd_pkg::ABD_BLOCK_BYTES) &&
				(next_st.keys == need)) begin
				next_st.start = 1'b1;
				next_st.state = abd_pkg::ABD_BUSY;
			end
		end

		// Placed after every clear so a finishing block is never lost
		if ((st.state == abd_pkg::ABD_BUSY) && core_done) begin
			next_st.done = 1'b1;
			next_st.state = abd_pkg::ABD_LOAD;
			next_st.pairs = '0;
			next_st.keys = '0;
			next_st.expect_key = 1'b0;
		end

		if (sfr_rd) begin
			if (hit_bcfg) begin
				next_st.rdata = {2'h0, st.done, 1'b0, st.enable, st.decrypt,
					st.key_size};
			end else if (hit_dcfg) begin
				next_st.rdata = {5'h00, st.out_sel, st.xor_in};
			end else if (hit_xin) begin
				next_st.rdata = st.xin;
			end else if (hit_yout) begin
				if (buf_valid) begin
					next_st.rdata = abd_result_byte(st.out_sel, buf_data,
						st.xin);
					buf_pop = !buf_clr;
				end else begin
					next_st.rdata = abd_pkg::ABD_UNMAPPED;
				end
			end else begin
				next_st.rdata = abd_pkg::ABD_UNMAPPED;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Entries pair the data byte with its inverse key byte
	abd_pair_buffer #(
		.WIDTH (abd_pkg::ABD_BUF_WIDTH),
		.DEPTH (abd_pkg::ABD_BUF_DEPTH)
	) abd_pair_buffer_inst (
		.clk       (clk),
		.rst_n     (rst_n),
		.clr       (buf_clr),
		.in_valid  (core_res_valid),
		.in_ready  (core_res_ready),
		.in_data   ({core_res_inv_key, core_res_data}),
		.out_valid (buf_valid),
		.out_ready (buf_pop),
		.out_data  (buf_data)
	);

	assign sfr_rdata = st.rdata;
	assign done_irq = st.done;
	assign core_key_size = st.key_size;
	assign core_decrypt = st.decrypt;
	assign core_enable = st.enable;
	assign core_in_valid = st.in_valid;
	assign core_in_data = st.in_data;
	assign core_in_is_key = st.in_is_key;
	assign core_start = st.start;

	reset_seq_a: assert property (@(posedge clk) disable iff (!rst_n)
		(sfr_wr && hit_bcfg && (sfr_wdata == 8'h00)) |=>
		((st.pairs == 5'h00) && (st.keys == 6'h00) && !core_enable))
		else $error("zero config write did not clear the sequence");

	key_count_a: assert property (@(posedge clk) disable iff (!rst_n)
		core_start |-> ((st.pairs == 5'h10) &&
		(st.keys == abd_pkg::abd_key_bytes(core_key_size))))
		else $error("core started with wrong byte count");

	dec_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
		(sfr_wr && hit_bcfg) |=> (core_decrypt == $past(sfr_wdata[2])))
		else $error("decrypt direction not taken from bit 2");

	enable_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		!st.enable |=> !core_in_valid)
		else $error("byte accepted while core disabled");

	pair_order_a: assert property (@(posedge clk) disable iff (!rst_n)
		(core_in_valid && !core_in_is_key) |-> (st.expect_key &&
		(st.pairs < 5'h10)))
		else $error("data byte out of alternating order");

	done_set_a: assert property (@(posedge clk) disable iff (!rst_n)
		((st.state == abd_pkg::ABD_BUSY) && core_done) |=>
		(done_irq && (st.state == abd_pkg::ABD_LOAD)))
		else $error("completion did not raise done");

	done_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(done_irq && !(sfr_wr && (hit_bcfg || hit_bin))) |=> done_irq)
		else $error("done flag dropped without a clear");

	cfg_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
		(core_done && !(sfr_wr && (hit_bcfg || hit_dcfg))) |=>
		($stable(core_key_size) && $stable(core_enable) &&
		$stable(st.out_sel)))
		else $error("configuration lost at block end");

	xor_in_a: assert property (@(posedge clk) disable iff (!rst_n)
		(acc_bin && st.xor_in) |=>
		(core_in_data == ($past(sfr_wdata) ^ $past(st.xin))))
		else $error("input XOR not applied");

	bypass_in_a: assert property (@(posedge clk) disable iff (!rst_n)
		(acc_bin && !st.xor_in) |=> (core_in_data == $past(sfr_wdata)))
		else $error("input byte altered with XOR off");

	dcfg_ro_a: assert property (@(posedge clk) disable iff (!rst_n)
		(sfr_rd && hit_dcfg) |=> (sfr_rdata[7:3] == 5'h00))
		else $error("read-only data config bits not zero");

	out_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
		(sfr_rd && hit_yout && buf_valid && (st.out_sel == 2'h2)) |=>
		(sfr_rdata == $past(buf_data[15:8])))
		else $error("inverse key not returned");

endmodule : abd_sfr_path

/* verification/abd_sfr_path_tb.sv */
// Self-checking bench for the block decrypt register front end
`timescale 1ns/1ps
module abd_sfr_path_tb;
	localparam logic [7:0] A_BCFG = abd_pkg::ABD_ADDR_BCFG;
	localparam logic [7:0] A_DCFG = abd_pkg::ABD_ADDR_DCFG;
	localparam logic [7:0] A_BIN  = abd_pkg::ABD_ADDR_BIN;
	localparam logic [7:0] A_KIN  = abd_pkg::ABD_ADDR_KIN;
	localparam logic [7:0] A_XIN  = abd_pkg::ABD_ADDR_XIN;
	localparam logic [7:0] A_YOUT = abd_pkg::ABD_ADDR_YOUT;
	logic       clk;
	logic       rst_n;
	logic [7:0] sfr_addr;
	logic       sfr_wr;
	logic       sfr_rd;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;
	logic       done_irq;
	logic [1:0] core_key_size;
	logic       core_decrypt;
	logic       core_enable;
	logic       core_in_valid;
	logic [7:0] core_in_data;
	logic       core_in_is_key;
	logic       core_start;
	logic       core_done;
	logic       core_res_valid;
	logic       core_res_ready;
	logic [7:0] core_res_data;
	logic [7:0] core_res_inv_key;
	int         errors;
	int         total_checks;
	int         seed;
	logic [9:0] in_q[$];
	logic [7:0] rd_q[$];
	logic       rd_prev = 1'b0;
	logic [7:0] res_d[16];
	logic [7:0] res_k[16];

	abd_sfr_path abd_sfr_path_inst (
		.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.done_irq(done_irq), .core_key_size(core_key_size),
		.core_decrypt(core_decrypt), .core_enable(core_enable),
		.core_in_valid(core_in_valid), .core_in_data(core_in_data),
		.core_in_is_key(core_in_is_key), .core_start(core_start),
		.core_done(core_done), .core_res_valid(core_res_valid),
		.core_res_ready(core_res_ready), .core_res_data(core_res_data),
		.core_res_inv_key(core_res_inv_key)
	);

	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : tick

	task automatic chk_val(input string nm, input logic [7:0] e,
			input logic [7:0] s);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask : chk_val

	task automatic chk_in(input logic [9:0] e, input logic [9:0] s);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("BAD core_in exp %h seen %h", e, s);
		end
	endtask : chk_in

	// Strobe then one idle edge, so no strobe is set twice in a step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		tick(1);
		sfr_wr = 1'b0;
		tick(1);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rd_q.push_back(e);
		sfr_addr = a;
		sfr_rd = 1'b1;
		tick(1);
		sfr_rd = 1'b0;
		tick(1);
	endtask : rd

	// Core side: hold each entry until ready was high at an edge
	task automatic feed();
		logic r;
		for (int i = 0; i < 16; i++) begin
			core_res_valid = 1'b1;
			core_res_data = res_d[i];
			core_res_inv_key = res_k[i];
			r = 1'b0;
			for (int w = 0; w < 200 && !r; w++) begin
				@(negedge clk);
				r = core_res_ready;
				@(posedge clk);
			end
			#2;
		end
		core_res_valid = 1'b0;
		// Released lines show no stale value
		core_res_data = ~core_res_data;
		core_res_inv_key = ~core_res_inv_key;
	endtask : feed

	always @(posedge clk) begin
		#1;
		if (rd_prev === 1'b1)
			chk_val("sfr_rdata", rd_q.pop_front(), sfr_rdata);
		if (core_in_valid === 1'b1)
			chk_in(in_q.size() ? in_q.pop_front() : 10'hXXX,
				{core_start, core_in_is_key, core_in_data});
		rd_prev = sfr_rd;
	end

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		#(40 * 20000);
		errors++;
		close_out();
	end

	initial begin
		logic [7:0] d, k, x, v;
		logic [1:0] ks;
		logic [1:0] sel;
		logic [5:0] need;
		errors = 0;
		total_checks = 0;
		seed = 15786;
		rst_n = 1'b0;
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
		core_done = 1'b0;
		core_res_valid = 1'b0;
		core_res_data = 8'h00;
		core_res_inv_key = 8'h00;
		tick(12);
		rst_n = 1'b1;
		chk_val("core_res_ready", 8'h01, {7'h00, core_res_ready});
		rd(A_DCFG, 8'h00);
		rd(8'h80, 8'h00);
		wr(A_DCFG, 8'hFF);
		rd(A_DCFG, 8'h07);
		wr(A_DCFG, 8'h00);
		rd(A_DCFG, 8'h00);
		wr(A_BCFG, 8'h00);
		chk_val("core_cfg", 8'h00, {4'h0, core_enable, core_decrypt,
			core_key_size});
		// Disabled core takes no bytes and no completion
		wr(A_BIN, 8'h5A);
		core_done = 1'b1;
		tick(1);
		core_done = 1'b0;
		tick(1);
		chk_val("done_irq", 8'h00, {7'h00, done_irq});
		// Last block runs the spare key code, which counts as 128-bit
		for (int b = 0; b < 5; b++) begin
			ks = (b == 4) ? 2'h3 : ((b == 3) ? 2'h2 : b[1:0]);
			sel = b[1:0];
			need = abd_pkg::ABD_KEY128;
			if (ks == 2'h1)
				need = abd_pkg::ABD_KEY192;
			if (ks == 2'h2)
				need = abd_pkg::ABD_KEY256;
			// Block 3 reuses the previous block config untouched
			if (b != 3) begin
				wr(A_BCFG, {6'h03, ks});
				chk_val("core_cfg", {4'h0, 2'h3, ks}, {4'h0,
					core_enable, core_decrypt, core_key_size});
			end
			x = 8'($random(seed));
			wr(A_XIN, x);
			wr(A_DCFG, {5'h1F, sel, b[0]});
			rd(A_DCFG, {5'h00, sel, b[0]});
			rd(A_XIN, x);
			wr(A_KIN, 8'hA5);
			for (int i = 0; i < 16; i++) begin
				d = 8'($random(seed));
				k = 8'($random(seed));
				in_q.push_back({2'h0, b[0] ? d ^ x : d});
				wr(A_BIN, d);
				if (i == 0)
					chk_val("done_irq", 8'h00, {7'h00, done_irq});
				in_q.push_back({i == 15 && need == 6'h10, 1'b1, k});
				wr(A_KIN, k);
			end
			for (int i = 16; i < need; i++) begin
				k = 8'($random(seed));
				in_q.push_back({i == need - 1, 1'b1, k});
				wr(A_KIN, k);
			end
			core_done = 1'b1;
			tick(1);
			core_done = 1'b0;
			chk_val("done_irq", 8'h01, {7'h00, done_irq});
			rd(A_BCFG, {4'h2, 2'h3, ks});
			for (int i = 0; i < 16; i++) begin
				res_d[i] = 8'($random(seed));
				res_k[i] = 8'($random(seed));
			end
			fork
				feed();
				begin
					tick(6);
					chk_val("core_res_ready", 8'h00,
						{7'h00, core_res_ready});
					for (int i = 0; i < 16; i++) begin
						case (sel)
							2'h1: v = res_d[i] ^ x;
							2'h2: v = res_k[i];
							default: v = res_d[i];
						endcase
						rd(A_YOUT, v);
						tick(1);
					end
				end
			join
			rd(A_YOUT, 8'h00);
			// Block 1 then sees done cleared by a block config write with bit 5 clear
			if (b == 1) begin
				wr(A_BCFG, {6'h03, ks});
				chk_val("done_irq", 8'h00, {7'h00, done_irq});
			end
		end
		tick(3);
		chk_val("in_q_left", 8'h00, 8'(in_q.size()));
		chk_val("rd_q_left", 8'h00, 8'(rd_q.size()));
		close_out();
	end
endmodule : abd_sfr_path_tb
